// ===== adcrm_cfg.svh
// Summary of operation
// - Every register is one 24-bit word, addressable and readable by itself.
// - A two-bit width field in status_and_comm selects the result presentation format.
// - Read grouping and write looping fields choose the set the pointer cycles through.
// - Address 0x00 returns the read-only channel 0 result, most significant bit first.
// - Address 0x01 returns the channel 1 result, most significant bit first; writes ignored.
// - Address 0x08 holds the modulator comparator outputs, readable and writable.
// - Address 0x0A holds the interchannel phase delay, readable and writable.
// - Address 0x0C holds status flags plus width and looping controls.
// - Offset trims sit at 0x0F for channel 0 and 0x11 for channel 1.
// - Gain trims sit at 0x10 for channel 0 and 0x12 for channel 1.
// - Address 0x1F holds a lock password and a CRC-16 over the nine config words 0x0A to 0x12.
// - Read code 11 whole map, 10 type, 01 group, 00 static; write bit loops type.
// - Gain trim is applied to results on chip when the host enables it.
`ifndef ADCRM_CFG_SVH
`define ADCRM_CFG_SVH

// Register addresses.
`define ADCRM_A_CH0 5'h00
`define ADCRM_A_CH1 5'h01
`define ADCRM_A_MOD 5'h08
`define ADCRM_A_PHASE 5'h0a
`define ADCRM_A_GAIN 5'h0b
`define ADCRM_A_STAT 5'h0c
`define ADCRM_A_CFG0 5'h0d
`define ADCRM_A_CFG1 5'h0e
`define ADCRM_A_OFF0 5'h0f
`define ADCRM_A_GTR0 5'h10
`define ADCRM_A_OFF1 5'h11
`define ADCRM_A_GTR1 5'h12
`define ADCRM_A_LOCK 5'h1f
`define ADCRM_A_FIRST 5'h00
`define ADCRM_A_LAST 5'h1f
`define ADCRM_CFG_LAST 4'h8

// Field positions.
`define ADCRM_SC_READ 23:22
`define ADCRM_SC_WRITE 21
`define ADCRM_SC_WIDTH 17:16
`define ADCRM_SC_DRDY 1:0
`define ADCRM_SC_KEEP 23:2
`define ADCRM_P0_EN_OFF 0
`define ADCRM_P0_EN_GAIN 1
`define ADCRM_PH_DELAY 11:0
`define ADCRM_LK_PASS 23:16
`define ADCRM_MOD_BITS 7:0
`define ADCRM_LOW16 15:0
`define ADCRM_HI16 23:8

// Reset values and codes.
`define ADCRM_MOD_RST 8'h33
`define ADCRM_SC_RST 24'ha10000
`define ADCRM_WIDTH_16 2'h0
`define ADCRM_RD_MAP 2'h3
`define ADCRM_RD_TYPE 2'h2
`define ADCRM_RD_GROUP 2'h1
`define ADCRM_RD_STATIC 2'h0
`define ADCRM_LOOP_STEPS 32
`define ADCRM_CRC_INIT 16'hffff
`define ADCRM_CRC_POLY 16'h8005
`define ADCRM_GAIN_SHIFT 23

`endif

// ===== adcrm_pkg.sv
package adcrm_pkg;
	typedef logic [4:0] adcrm_addr_type;
	typedef logic [23:0] adcrm_word_type;
	typedef enum logic [1:0] {ADCRM_IDLE, ADCRM_READ, ADCRM_WRITE} adcrm_xfer_type;

	// One access request from the serial framer.
	typedef struct packed {
		logic start;
		logic write;
		adcrm_addr_type addr;
	} adcrm_acc_type;

	// A pair of fresh conversion results.
	typedef struct packed {
		logic valid;
		adcrm_word_type ch0;
		adcrm_word_type ch1;
	} adcrm_sample_type;

	// Whole register bank state.
	typedef struct packed {
		adcrm_xfer_type xfer;
		adcrm_addr_type ptr;
		adcrm_word_type rdata;
		adcrm_word_type res0;
		adcrm_word_type res1;
		logic pend;
		adcrm_word_type pend0;
		adcrm_word_type pend1;
		logic [7:0] modulator_output;
		adcrm_word_type [8:0] cfg;
		logic [7:0] lock;
		logic [15:0] crc;
		logic [15:0] crc_acc;
		logic [3:0] scan;
		logic [1:0] drdy;
		logic restart;
	} adcrm_state_type;
endpackage : adcrm_pkg

// ===== adcrm_loop_ptr.sv
`timescale 1ns/1ns
`include "adcrm_cfg.svh"
module adcrm_loop_ptr (
	input wire adcrm_pkg::adcrm_addr_type addr,
	input wire logic [1:0] read_mode,
	input wire logic write_loop,
	input wire logic is_write,
	output adcrm_pkg::adcrm_addr_type next_addr
);
	import adcrm_pkg::*;

	// Only mapped words count; holes are never visited.
	function automatic logic mapped(adcrm_addr_type a);
		return (a <= `ADCRM_A_CH1) || (a == `ADCRM_A_MOD) || (a == `ADCRM_A_LOCK)
			|| ((a >= `ADCRM_A_PHASE) && (a <= `ADCRM_A_GTR1));
	endfunction : mapped

	adcrm_addr_type lo;
	adcrm_addr_type hi;
	adcrm_addr_type cand;
	logic found;

	// Pick the loop set, then walk to the next mapped word inside it.
	always_comb begin
		lo = addr;
		hi = addr;
		if (is_write) begin
			if (write_loop) begin
				lo = `ADCRM_A_MOD;
				hi = `ADCRM_A_LAST;
			end
		end else begin
			unique case (read_mode)
				`ADCRM_RD_MAP: begin
					lo = `ADCRM_A_FIRST;
					hi = `ADCRM_A_LAST;
				end
				`ADCRM_RD_TYPE: begin
					lo = (addr <= `ADCRM_A_CH1) ? `ADCRM_A_CH0 : `ADCRM_A_MOD;
					hi = (addr <= `ADCRM_A_CH1) ? `ADCRM_A_CH1 : `ADCRM_A_LAST;
				end
				`ADCRM_RD_GROUP: begin
					if (addr <= `ADCRM_A_CH1) begin
						lo = `ADCRM_A_CH0;
						hi = `ADCRM_A_CH1;
					end else if (addr <= `ADCRM_A_PHASE) begin
						lo = `ADCRM_A_MOD;
						hi = `ADCRM_A_PHASE;
					end else if (addr <= `ADCRM_A_CFG0) begin
						lo = `ADCRM_A_GAIN;
						hi = `ADCRM_A_CFG0;
					end else if (addr <= `ADCRM_A_GTR0) begin
						lo = `ADCRM_A_CFG1;
						hi = `ADCRM_A_GTR0;
					end else if (addr <= `ADCRM_A_GTR1) begin
						lo = `ADCRM_A_OFF1;
						hi = `ADCRM_A_GTR1;
					end else begin
						lo = `ADCRM_A_LOCK;
						hi = `ADCRM_A_LOCK;
					end
				end
				`ADCRM_RD_STATIC: begin
					// Static reads keep the pointer where it is.
				end
			endcase
		end
		cand = addr;
		found = 1'b0;
		next_addr = addr;
		// Thirty-two steps always cover the widest hole.
		for (int i = 0; i < `ADCRM_LOOP_STEPS; i++) begin
			if (!found) begin
				cand = ((cand >= hi) || (cand < lo)) ? lo : adcrm_addr_type'(cand + 5'h01);
				if (mapped(cand)) begin
					found = 1'b1;
					next_addr = cand;
				end
			end
		end
	end
endmodule : adcrm_loop_ptr

// ===== adcrm_regmap.sv
`timescale 1ns/1ns
`include "adcrm_cfg.svh"
module adcrm_regmap #(
	parameter int unsigned WORD_W = 24,
	parameter logic [7:0] UNLOCK_CODE = 8'ha5
) (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire adcrm_pkg::adcrm_acc_type host_acc,
	input wire logic wr_valid,
	input wire adcrm_pkg::adcrm_word_type wr_data,
	input wire logic rd_next,
	input wire logic acc_end,
	output adcrm_pkg::adcrm_word_type rd_data,
	output adcrm_pkg::adcrm_addr_type cur_addr,
	input wire adcrm_pkg::adcrm_sample_type sample,
	input wire logic comp_valid,
	input wire logic [7:0] comp_bits,
	output logic [11:0] phase_delay,
	output adcrm_pkg::adcrm_word_type amp_gain_cfg,
	output adcrm_pkg::adcrm_word_type primary_cfg,
	output adcrm_pkg::adcrm_word_type secondary_cfg,
	output logic gain_trim_enable,
	output logic adc_restart,
	output logic locked
);
	import adcrm_pkg::*;

	// The word handling below is written for the fixed register width only.
	if (WORD_W != 24) begin : g_width_check
		$error("adcrm_regmap supports only 24-bit registers");
	end
	if (UNLOCK_CODE == 8'h00) begin : g_code_check
		$error("adcrm_regmap needs a nonzero unlock code");
	end

	adcrm_state_type state;
	adcrm_state_type next_state;
	adcrm_addr_type step_addr;
	logic step_write;

	// Index of a config word held in the cfg array.
	function automatic logic [3:0] cfg_idx(adcrm_addr_type a);
		return 4'(a - `ADCRM_A_PHASE);
	endfunction : cfg_idx

	function automatic logic is_cfg(adcrm_addr_type a);
		return (a >= `ADCRM_A_PHASE) && (a <= `ADCRM_A_GTR1);
	endfunction : is_cfg

	// One CRC-16 update over a whole 24-bit word, MSB first.
	function automatic logic [15:0] crc_word(logic [15:0] c, adcrm_word_type w);
		logic [15:0] r;
		logic fb;
		r = c;
		for (int i = 23; i >= 0; i--) begin
			fb = r[15] ^ w[i];
			r = {r[14:0], 1'b0};
			if (fb) begin
				r = r ^ `ADCRM_CRC_POLY;
			end
		end
		return r;
	endfunction : crc_word

	// Offset, then gain trim; gain trim is a signed fraction around unity.
	function automatic adcrm_word_type calibrate(adcrm_word_type raw, adcrm_word_type off,
		adcrm_word_type gtr, logic en_off, logic en_gain);
		logic signed [23:0] s;
		logic signed [47:0] p;
		s = en_off ? 24'(raw + off) : raw;
		p = 48'(s) * 48'(signed'(gtr));
		if (en_gain) begin
			s = 24'(s + 24'(p >>> `ADCRM_GAIN_SHIFT));
		end
		return adcrm_word_type'(s);
	endfunction : calibrate

	// 16-bit mode keeps the top of the word so it still leaves MSB first.
	function automatic adcrm_word_type present(adcrm_word_type w, logic [1:0] width);
		if (width == `ADCRM_WIDTH_16) begin
			return {w[`ADCRM_HI16], 8'h00};
		end
		return w;
	endfunction : present

	// Read view of one address; holes return zero.
	function automatic adcrm_word_type read_word(adcrm_state_type s, adcrm_addr_type a);
		adcrm_word_type w;
		w = '0;
		if (a == `ADCRM_A_CH0) begin
			w = s.res0;
		end else if (a == `ADCRM_A_CH1) begin
			w = s.res1;
		end else if (a == `ADCRM_A_MOD) begin
			w = {16'h0000, s.modulator_output};
		end else if (a == `ADCRM_A_PHASE) begin
			w = {12'h000, s.cfg[cfg_idx(a)][`ADCRM_PH_DELAY]};
		end else if (a == `ADCRM_A_STAT) begin
			w = {s.cfg[cfg_idx(a)][`ADCRM_SC_KEEP], s.drdy};
		end else if (is_cfg(a)) begin
			w = s.cfg[cfg_idx(a)];
		end else if (a == `ADCRM_A_LOCK) begin
			w = {s.lock, s.crc};
		end
		return w;
	endfunction : read_word

	logic [1:0] read_mode;
	logic write_loop;
	adcrm_word_type stat_word;
	adcrm_word_type cfg0_word;

	assign stat_word = state.cfg[cfg_idx(`ADCRM_A_STAT)];
	assign cfg0_word = state.cfg[cfg_idx(`ADCRM_A_CFG0)];
	assign read_mode = stat_word[`ADCRM_SC_READ];
	assign write_loop = stat_word[`ADCRM_SC_WRITE];
	assign step_write = (state.xfer == ADCRM_WRITE);

	// Pointer stepping for continuous transfers lives in its own decoder.
	adcrm_loop_ptr adcrm_loop_ptr_inst (
		.addr(state.ptr),
		.read_mode(read_mode),
		.write_loop(write_loop),
		.is_write(step_write),
		.next_addr(step_addr)
	);

	adcrm_word_type cal0;
	adcrm_word_type cal1;
	logic reading_data;
	logic [1:0] drdy_clr;
	logic [3:0] ci;

	// Results are formed here so a latch point sees finished words.
	always_comb begin
		cal0 = present(calibrate(sample.ch0, state.cfg[cfg_idx(`ADCRM_A_OFF0)],
			state.cfg[cfg_idx(`ADCRM_A_GTR0)], cfg0_word[`ADCRM_P0_EN_OFF],
			cfg0_word[`ADCRM_P0_EN_GAIN]), stat_word[`ADCRM_SC_WIDTH]);
		cal1 = present(calibrate(sample.ch1, state.cfg[cfg_idx(`ADCRM_A_OFF1)],
			state.cfg[cfg_idx(`ADCRM_A_GTR1)], cfg0_word[`ADCRM_P0_EN_OFF],
			cfg0_word[`ADCRM_P0_EN_GAIN]), stat_word[`ADCRM_SC_WIDTH]);
	end

	// Next state: access sequencing, writes, result latching and the CRC scan.
	always_comb begin
		next_state = state;
		next_state.restart = 1'b0;
		drdy_clr = 2'b00;
		ci = '0;
		reading_data = (state.xfer == ADCRM_READ) && (state.ptr <= `ADCRM_A_CH1);

		// Access sequencing.
		if (host_acc.start) begin
			next_state.ptr = host_acc.addr;
			next_state.xfer = host_acc.write ? ADCRM_WRITE : ADCRM_READ;
			next_state.rdata = read_word(state, host_acc.addr);
			if (!host_acc.write && host_acc.addr <= `ADCRM_A_CH1) begin
				drdy_clr[host_acc.addr[0]] = 1'b1;
			end
		end else if (acc_end) begin
			next_state.xfer = ADCRM_IDLE;
		end else if (state.xfer == ADCRM_READ && rd_next) begin
			next_state.ptr = step_addr;
			next_state.rdata = read_word(state, step_addr);
			if (step_addr <= `ADCRM_A_CH1) begin
				drdy_clr[step_addr[0]] = 1'b1;
			end
		end else if (state.xfer == ADCRM_WRITE && wr_valid) begin
			next_state.ptr = step_addr;
			// While locked only the security word still takes writes.
			if (!locked || state.ptr == `ADCRM_A_LOCK) begin
				if (state.ptr == `ADCRM_A_MOD) begin
					next_state.modulator_output = wr_data[`ADCRM_MOD_BITS];
				end else if (is_cfg(state.ptr)) begin
					ci = cfg_idx(state.ptr);
					next_state.cfg[ci] = wr_data;
					if (state.ptr == `ADCRM_A_PHASE) begin
						next_state.cfg[ci] = {12'h000, wr_data[`ADCRM_PH_DELAY]};
						next_state.restart = 1'b1;
					end
				end else if (state.ptr == `ADCRM_A_LOCK) begin
					next_state.lock = wr_data[`ADCRM_LK_PASS];
				end
			end
		end

		// Live comparator outputs win over a host write in the same cycle.
		if (comp_valid) begin
			next_state.modulator_output = comp_bits;
		end

		// Flags clear on read; a fresh sample in the same cycle keeps them set.
		next_state.drdy = state.drdy & ~drdy_clr;

		// Results stay frozen while a channel word is being shifted out.
		if (sample.valid) begin
			if (reading_data && !acc_end) begin
				next_state.pend = 1'b1;
				next_state.pend0 = cal0;
				next_state.pend1 = cal1;
			end else begin
				next_state.res0 = cal0;
				next_state.res1 = cal1;
				next_state.pend = 1'b0;
			end
			next_state.drdy = 2'b11;
		end else if (state.pend && (!reading_data || acc_end)) begin
			next_state.res0 = state.pend0;
			next_state.res1 = state.pend1;
			next_state.pend = 1'b0;
			next_state.drdy = 2'b11;
		end

		// The CRC walks one config word per cycle and refreshes after the last.
		next_state.crc_acc = crc_word(state.crc_acc, state.cfg[state.scan]);
		next_state.scan = 4'(state.scan + 4'h1);
		if (state.scan == `ADCRM_CFG_LAST) begin
			next_state.crc = next_state.crc_acc;
			next_state.crc_acc = `ADCRM_CRC_INIT;
			next_state.scan = '0;
		end
	end

	// Reset values; clock enable low freezes everything.
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			state <= '0;
			state.xfer <= ADCRM_IDLE;
			state.modulator_output <= `ADCRM_MOD_RST;
			state.cfg[cfg_idx(`ADCRM_A_STAT)] <= `ADCRM_SC_RST;
			state.lock <= UNLOCK_CODE;
			state.crc_acc <= `ADCRM_CRC_INIT;
		end else if (clk_en) begin
			state <= next_state;
		end
	end

	// All outputs but locked come straight from the state register; locked compares the stored password with UNLOCK_CODE.
	assign rd_data = state.rdata;
	assign cur_addr = state.ptr;
	assign phase_delay = state.cfg[cfg_idx(`ADCRM_A_PHASE)][`ADCRM_PH_DELAY];
	assign amp_gain_cfg = state.cfg[cfg_idx(`ADCRM_A_GAIN)];
	assign primary_cfg = cfg0_word;
	assign secondary_cfg = state.cfg[cfg_idx(`ADCRM_A_CFG1)];
	assign gain_trim_enable = cfg0_word[`ADCRM_P0_EN_GAIN];
	assign adc_restart = state.restart;
	assign locked = (state.lock != UNLOCK_CODE);
endmodule : adcrm_regmap

// ===== adcrm_regmap_asserts.sv
`timescale 1ns/1ns
module adcrm_regmap_asserts (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire adcrm_pkg::adcrm_acc_type host_acc,
	input wire logic wr_valid,
	input wire logic rd_next,
	input wire logic acc_end,
	input wire adcrm_pkg::adcrm_word_type rd_data,
	input wire adcrm_pkg::adcrm_addr_type cur_addr,
	input wire logic [11:0] phase_delay,
	input wire adcrm_pkg::adcrm_word_type primary_cfg,
	input wire logic gain_trim_enable,
	input wire logic adc_restart
);
	import adcrm_pkg::*;
	// All checks share the system clock and stay quiet while reset is held.
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	logic rd_go;
	// A read transfer accepted in this cycle.
	assign rd_go = clk_en && host_acc.start && !host_acc.write;
	function automatic logic hole(input adcrm_addr_type a);
		return a inside {[5'h02:5'h07], 5'h09, [5'h13:5'h1e]};
	endfunction : hole
	a_start_ptr: assert property (clk_en && host_acc.start |=> cur_addr == $past(host_acc.addr))
		else $error("pointer did not load the start address");
	a_hole_zero: assert property (rd_go && hole(host_acc.addr) |=> rd_data == 24'h000000)
		else $error("unused address did not read zero");
	a_hole_skip: assert property (clk_en && rd_next && !host_acc.start && !acc_end &&
		!hole(cur_addr) |=> !hole(cur_addr)) else $error("looping landed on an unused address");
	a_phase_read: assert property (rd_go && host_acc.addr == 5'h0a |=>
		rd_data == {12'h000, phase_delay}) else $error("phase read differs from phase output");
	a_mod_upper: assert property (rd_go && host_acc.addr == 5'h08 |=> rd_data[23:8] == 16'h0000)
		else $error("modulator word has upper bits set");
	a_gain_link: assert property (rd_go && host_acc.addr == 5'h0d |=>
		rd_data == primary_cfg && gain_trim_enable == rd_data[1]) else $error("gain enable mismatch");
	a_restart_once: assert property (clk_en && adc_restart |=> !adc_restart)
		else $error("restart pulse longer than one cycle");
	a_restart_cause: assert property ($rose(adc_restart) |->
		$past(clk_en && wr_valid && cur_addr == 5'h0a)) else $error("restart without phase write");
endmodule : adcrm_regmap_asserts

bind adcrm_regmap adcrm_regmap_asserts adcrm_regmap_asserts_inst (.clk_sys(clk_sys),
	.reset_n(reset_n), .clk_en(clk_en), .host_acc(host_acc), .wr_valid(wr_valid),
	.rd_next(rd_next), .acc_end(acc_end), .rd_data(rd_data), .cur_addr(cur_addr),
	.phase_delay(phase_delay), .primary_cfg(primary_cfg), .gain_trim_enable(gain_trim_enable),
	.adc_restart(adc_restart));

// ===== adcrm_host_model.sv
`timescale 1ns/1ns
module adcrm_host_model (
	input wire logic clk_sys,
	output adcrm_pkg::adcrm_acc_type host_acc,
	output logic wr_valid,
	output adcrm_pkg::adcrm_word_type wr_data,
	output logic rd_next,
	output logic acc_end
);
	import adcrm_pkg::*;
	// Idle host; the write word toggles so a stale value is never mistaken for data.
	initial begin
		host_acc = '0;
		wr_valid = 1'b0;
		wr_data = 24'h5a5a5a;
		rd_next = 1'b0;
		acc_end = 1'b0;
	end
	// Every strobe lasts one cycle and is followed by an idle cycle.
	task open(input adcrm_addr_type a, input logic w);
		host_acc = '{start: 1'b1, write: w, addr: a};
		@(negedge clk_sys);
		host_acc.start = 1'b0;
		@(negedge clk_sys);
	endtask : open
	task put(input adcrm_word_type d);
		wr_data = d;
		wr_valid = 1'b1;
		@(negedge clk_sys);
		wr_valid = 1'b0;
		wr_data = ~d;
		@(negedge clk_sys);
	endtask : put
	task step;
		rd_next = 1'b1;
		@(negedge clk_sys);
		rd_next = 1'b0;
		@(negedge clk_sys);
	endtask : step
	task close;
		acc_end = 1'b1;
		@(negedge clk_sys);
		acc_end = 1'b0;
		@(negedge clk_sys);
	endtask : close
endmodule : adcrm_host_model

// ===== adcrm_regmap_tb.sv
`timescale 1ns/1ns
module adcrm_regmap_tb;
	import adcrm_pkg::*;
	logic clk_sys, reset_n, wr_valid, rd_next, acc_end, comp_valid, gain_trim_enable, locked;
	logic clk_en;
	logic [11:0] phase_delay;
	adcrm_word_type amp_gain_cfg, secondary_cfg;
	logic [7:0] comp_bits;
	adcrm_acc_type host_acc;
	adcrm_sample_type sample;
	adcrm_word_type wr_data, rd_data, q;
	adcrm_addr_type cur_addr;
	int n_fail = 0;
	int samples_checked = 0;
	logic [1:0] md [4] = '{2'h3, 2'h2, 2'h1, 2'h0};
	adcrm_addr_type st [4] = '{5'h12, 5'h01, 5'h0c, 5'h0f};
	adcrm_addr_type nx [4] = '{5'h1f, 5'h00, 5'h0d, 5'h0f};
	adcrm_regmap adcrm_regmap_inst (.clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en),
		.host_acc(host_acc), .wr_valid(wr_valid), .wr_data(wr_data), .rd_next(rd_next),
		.acc_end(acc_end), .rd_data(rd_data), .cur_addr(cur_addr), .sample(sample),
		.comp_valid(comp_valid), .comp_bits(comp_bits), .phase_delay(phase_delay),
		.amp_gain_cfg(amp_gain_cfg), .primary_cfg(), .secondary_cfg(secondary_cfg),
		.gain_trim_enable(gain_trim_enable),
		.adc_restart(), .locked(locked));
	adcrm_host_model adcrm_host_model_inst (.clk_sys(clk_sys), .host_acc(host_acc),
		.wr_valid(wr_valid), .wr_data(wr_data), .rd_next(rd_next), .acc_end(acc_end));
	// Free-running system clock.
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	task check(input adcrm_word_type seen, input adcrm_word_type exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	// Reference CRC-16 over the nine config words, lowest address first, MSB first.
	function automatic logic [15:0] crc16(input adcrm_word_type [8:0] w);
		logic [15:0] r;
		r = 16'hffff;
		for (int k = 0; k < 9; k++) begin
			for (int b = 23; b >= 0; b--) begin
				r = (r[15] ^ w[k][b]) ? ({r[14:0], 1'b0} ^ 16'h8005) : {r[14:0], 1'b0};
			end
		end
		return r;
	endfunction : crc16
	task wr_reg(input adcrm_addr_type a, input adcrm_word_type d);
		adcrm_host_model_inst.open(a, 1'b1);
		adcrm_host_model_inst.put(d);
		adcrm_host_model_inst.close();
	endtask : wr_reg
	task rd_reg(input adcrm_addr_type a, output adcrm_word_type d);
		adcrm_host_model_inst.open(a, 1'b0);
		d = rd_data;
		adcrm_host_model_inst.close();
	endtask : rd_reg
	task push(input adcrm_word_type c0, input adcrm_word_type c1);
		sample = '{valid: 1'b1, ch0: c0, ch1: c1};
		@(negedge clk_sys);
		sample.valid = 1'b0;
		@(negedge clk_sys);
	endtask : push
	task results;
		$display("Checks %0d, mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : results
	// A hang counts as a mismatch; the bound is far above the sequence length.
	initial begin
		#500000;
		n_fail++;
		results();
	end
	// Main sequence; inputs move only at falling edges.
	initial begin
		reset_n = 1'b0;
		sample = '0;
		comp_valid = 1'b0;
		comp_bits = 8'h00;
		clk_en = 1'b1;
		repeat (3) @(negedge clk_sys);
		reset_n = 1'b1;
		@(negedge clk_sys);
		rd_reg(5'h0c, q); check(q, 24'ha10000);
		rd_reg(5'h08, q); check(q, 24'h000033);
		wr_reg(5'h05, 24'hffffff); rd_reg(5'h05, q); check(q, 24'h000000);
		wr_reg(5'h0a, 24'hfff123); rd_reg(5'h0a, q); check(q, 24'h000123);
		check({12'h000, phase_delay}, 24'h000123);
		comp_bits = 8'h5a;
		comp_valid = 1'b1;
		@(negedge clk_sys);
		comp_valid = 1'b0;
		rd_reg(5'h08, q); check(q, 24'h00005a);
		// With the clock enable low a comparator update must not land.
		clk_en = 1'b0;
		comp_bits = 8'ha5;
		comp_valid = 1'b1;
		@(negedge clk_sys);
		comp_valid = 1'b0;
		clk_en = 1'b1;
		rd_reg(5'h08, q); check(q, 24'h00005a);
		$display("Test defaults done");
		// Each row sets a grouping code and write bit, then steps once each way.
		for (int i = 0; i < 4; i++) begin
			wr_reg(5'h0c, {md[i], md[i][0], 3'b000, 2'b01, 16'h0000});
			adcrm_host_model_inst.open(st[i], 1'b0);
			adcrm_host_model_inst.step();
			check({19'h0, cur_addr}, {19'h0, nx[i]});
			adcrm_host_model_inst.close();
			adcrm_host_model_inst.open(5'h0a, 1'b1);
			adcrm_host_model_inst.put(24'h000123);
			check({19'h0, cur_addr}, md[i][0] ? 24'h00000b : 24'h00000a);
			adcrm_host_model_inst.close();
		end
		$display("Test looping done");
		for (int i = 0; i < 4; i++) wr_reg(5'h0f + 5'(i), 24'h100000 + 24'(i));
		for (int i = 0; i < 4; i++) begin
			rd_reg(5'h0f + 5'(i), q); check(q, 24'h100000 + 24'(i));
		end
		wr_reg(5'h0b, 24'h00000c); check(amp_gain_cfg, 24'h00000c);
		wr_reg(5'h0e, 24'h00000e); check(secondary_cfg, 24'h00000e);
		$display("Test trims done");
		push(24'h123456, 24'habcdef);
		wr_reg(5'h00, 24'h000000); wr_reg(5'h01, 24'h000000);
		rd_reg(5'h00, q); check(q, 24'h123456);
		rd_reg(5'h01, q); check(q, 24'habcdef);
		// The width code applies when a result is latched, so a fresh sample follows.
		wr_reg(5'h0c, 24'h000000);
		push(24'h123456, 24'habcdef);
		rd_reg(5'h0c, q); check(q, 24'h000003);
		rd_reg(5'h00, q); check(q, 24'h123400);
		rd_reg(5'h01, q); check(q, 24'habcd00);
		rd_reg(5'h0c, q); check(q, 24'h000000);
		// A sample that lands while channel 0 is being read waits for the transfer end.
		adcrm_host_model_inst.open(5'h00, 1'b0);
		push(24'h654321, 24'h000000);
		adcrm_host_model_inst.step();
		check(rd_data, 24'h123400);
		adcrm_host_model_inst.close();
		rd_reg(5'h00, q); check(q, 24'h654300);
		$display("Test results done");
		wr_reg(5'h0d, 24'h000002);
		rd_reg(5'h0d, q); check(q, 24'h000002);
		check({23'h0, gain_trim_enable}, 24'h000001);
		push(24'h100000, 24'h000000);
		rd_reg(5'h00, q); check(q, 24'h120000);
		$display("Test gain done");
		wr_reg(5'h1f, 24'h000000); check({23'h0, locked}, 24'h000001);
		wr_reg(5'h0a, 24'h000456); rd_reg(5'h0a, q); check(q, 24'h000123);
		rd_reg(5'h1f, q); check({16'h0, q[23:16]}, 24'h000000);
		check({8'h00, q[15:0]}, {8'h00, crc16({24'h100003, 24'h100002, 24'h100001,
			24'h100000, 24'h00000e, 24'h000002, 24'h000000, 24'h00000c, 24'h000123})});
		wr_reg(5'h1f, 24'ha50000); check({23'h0, locked}, 24'h000000);
		$display("Test lock done");
		results();
	end
endmodule : adcrm_regmap_tb
